// ---- src/ctpg_map.vh ----
`ifndef CTPG_MAP_VH
`define CTPG_MAP_VH
// Register byte offsets
`define CTPG_REG_CTRL      8'h00
`define CTPG_REG_FRAMES    8'h04
`define CTPG_REG_PULSES    8'h08
`define CTPG_REG_DELAY     8'h0C
`define CTPG_REG_PG_CFG    8'h10
`define CTPG_REG_PG_PERIOD 8'h14
`define CTPG_REG_PG_WIDTH  8'h18
`define CTPG_REG_PG_COUNT  8'h1C
`define CTPG_REG_PG_CMD    8'h20
`define CTPG_REG_STATUS    8'h24
`define CTPG_REG_SW_TRIG   8'h28
// CTRL fields
`define CTPG_SRC_LSB   0
`define CTPG_MODE_LSB  4
`define CTPG_OVL_LSB   8
`define CTPG_EDGE_BIT  10
`define CTPG_DEB_LSB   12
`define CTPG_POL_LSB   16
// Source codes
`define CTPG_SRC_OFF   3'h0
`define CTPG_SRC_EXT   3'h1
`define CTPG_SRC_PGEN  3'h2
`define CTPG_SRC_GRAB  3'h3
`define CTPG_SRC_SOFT  3'h4
// Mode codes
`define CTPG_MODE_STD  3'h0
`define CTPG_MODE_FAST 3'h1
`define CTPG_MODE_DBL  3'h2
`define CTPG_MODE_ACC  3'h3
`define CTPG_MODE_ASYN 3'h4
// Overlap codes
`define CTPG_OVL_IGN   2'h0
`define CTPG_OVL_ACC   2'h1
`define CTPG_OVL_AEXP  2'h2
// Reset values and frame count limit
`define CTPG_CTRL_RST   32'h0000_3000
`define CTPG_FRAMES_RST 32'h0000_0001
`define CTPG_PULSES_RST 32'h0000_0001
`define CTPG_FRAMES_MAX 17'h0FFDC
// Timing
`define CTPG_CLK_MHZ    250
`define CTPG_US_CYC     (`CTPG_CLK_MHZ)
`define CTPG_US_LAST    8'hF9
`define CTPG_EXP_NS     1000
`define CTPG_EXP_CYC    (`CTPG_EXP_NS * `CTPG_CLK_MHZ / 1000)
`endif

// ---- src/ctpg_top.v ----
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "ctpg_map.vh"
module ctpg_top
#(
   parameter EXP_CYC = `CTPG_EXP_CYC,
   parameter RD_CYC  = 1000
)
(
   // Clock and reset
   input  wire        clk_i,
   input  wire        sys_rst_i,
   // AXI4-Lite slave
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Trigger pins
   input  wire        ext_trig_input_a_i,
   input  wire        ext_trig_input_b_i,
   input  wire        grabber_ctrl_input_a_i,
   input  wire        grabber_ctrl_input_b_i,
   // Sensor timing core
   input  wire        frame_done_i,
   output reg         expose_o,
   output reg         transfer_o,
   output reg         readout_o,
   output reg         timing_reset_o,
   output reg         free_run_o,
   output reg         trig_delayed_o,
   output reg         pulse_gen_o
);

   // Sequencer states, one-hot
   localparam ST_IDLE = 4'b0001;
   localparam ST_DLY  = 4'b0010;
   localparam ST_EXP  = 4'b0100;
   localparam ST_RD   = 4'b1000;

   reg [31:0] ctrl;
   reg [16:0] frames;
   reg [15:0] pulses;
   reg [23:0] delay_us;
   reg [1:0]  pg_gran;
   reg        pg_fixed;
   reg [31:0] pg_period;
   reg [31:0] pg_width;
   reg [16:0] pg_count;
   reg        pg_run;
   reg        soft_trig;
   reg        pg_toggle;

   wire [2:0] src  = ctrl[`CTPG_SRC_LSB +: 3];
   wire [2:0] mode = ctrl[`CTPG_MODE_LSB +: 3];
   wire [1:0] ovl  = ctrl[`CTPG_OVL_LSB +: 2];
   wire [2:0] deb  = ctrl[`CTPG_DEB_LSB +: 3];
   wire [3:0] pol  = ctrl[`CTPG_POL_LSB +: 4];

   // Debounce lengths in microseconds
   function [13:0] deb_us;
      input [2:0] sel;
      case (sel)
         3'h1:    deb_us = 14'd10;
         3'h2:    deb_us = 14'd50;
         3'h3:    deb_us = 14'd100;
         3'h4:    deb_us = 14'd500;
         3'h5:    deb_us = 14'd1000;
         3'h6:    deb_us = 14'd5000;
         3'h7:    deb_us = 14'd10000;
         default: deb_us = 14'd0;
      endcase
   endfunction

   // Granularity multiplier
   function [9:0] gran_mul;
      input [1:0] g;
      case (g)
         2'h1:    gran_mul = 10'd10;
         2'h2:    gran_mul = 10'd100;
         2'h3:    gran_mul = 10'd1000;
         default: gran_mul = 10'd1;
      endcase
   endfunction

   // One microsecond tick
   reg [7:0] us_cnt;
   wire      us_tick = (us_cnt == `CTPG_US_LAST);
   always @(posedge clk_i)
   begin
      if (sys_rst_i || us_tick || pg_toggle)
         us_cnt <= 8'h00;
      else
         us_cnt <= us_cnt + 8'h01;
   end

   // Pin synchronisers, polarity and debounce per input
   wire [3:0] pins = {grabber_ctrl_input_b_i, grabber_ctrl_input_a_i,
                      ext_trig_input_b_i, ext_trig_input_a_i};
   wire [3:0] clean;
   wire [31:0] deb_full = deb_us(deb) * `CTPG_US_CYC;
   wire [21:0] deb_lim  = deb_full[21:0];
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1)
      begin : g_in
         reg        s1;
         reg        s2;
         reg        stab;
         reg [21:0] dcnt;
         always @(posedge clk_i)
         begin
            if (sys_rst_i)
            begin
               s1   <= 1'b0;
               s2   <= 1'b0;
               stab <= 1'b0;
               dcnt <= 22'h000000;
            end
            else
            begin
               s1 <= pins[gi];
               s2 <= s1;
               if ((s2 ^ pol[gi]) == stab)
                  dcnt <= 22'h000000;
               else if (dcnt + 22'h000001 >= deb_lim)
               begin
                  stab <= s2 ^ pol[gi];
                  dcnt <= 22'h000000;
               end
               else
                  dcnt <= dcnt + 22'h000001;
            end
         end
         assign clean[gi] = stab;
      end
   endgenerate

   // Source select and edge detect
   reg sel_lvl;
   reg sel_prev;
   always @*
   begin
      case (src)
         `CTPG_SRC_EXT:  sel_lvl = clean[0] | clean[1];
         `CTPG_SRC_GRAB: sel_lvl = clean[2] | clean[3];
         `CTPG_SRC_PGEN: sel_lvl = pulse_gen_o;
         default:        sel_lvl = 1'b0;
      endcase
   end
   wire edge_r = sel_lvl & ~sel_prev;
   wire edge_f = ~sel_lvl & sel_prev;
   wire trig_edge = (src == `CTPG_SRC_OFF) ? 1'b0 :
                    (src == `CTPG_SRC_SOFT) ? soft_trig :
                    (ctrl[`CTPG_EDGE_BIT] ? edge_f : edge_r);

   // Acquisition sequencer
   reg [3:0]  state;
   reg [23:0] dly_cnt;
   reg [7:0]  dly_sub;
   reg [31:0] cyc_cnt;
   reg [16:0] frm_cnt;
   reg [15:0] acc_cnt;
   reg        pend;
   wire busy = (state != ST_IDLE);
   wire take = trig_edge && (!busy || ovl == `CTPG_OVL_ACC ||
               (ovl == `CTPG_OVL_AEXP && state != ST_EXP));
   wire [16:0] nfr = (mode == `CTPG_MODE_DBL) ? 17'd2 : frames;
   always @(posedge clk_i)
   begin
      sel_prev <= sys_rst_i ? 1'b0 : sel_lvl;
      if (sys_rst_i)
      begin
         state <= ST_IDLE; dly_cnt <= 24'h0; cyc_cnt <= 32'h0;
         dly_sub <= 8'h00;
         frm_cnt <= 17'h0; acc_cnt <= 16'h0; pend <= 1'b0;
         expose_o <= 1'b0; transfer_o <= 1'b0; readout_o <= 1'b0;
         timing_reset_o <= 1'b0; free_run_o <= 1'b1; trig_delayed_o <= 1'b0;
      end
      else
      begin
         transfer_o     <= 1'b0;
         timing_reset_o <= 1'b0;
         trig_delayed_o <= 1'b0;
         free_run_o <= (src == `CTPG_SRC_OFF) ||
                       (mode == `CTPG_MODE_ASYN && !busy) ||
                       (mode == `CTPG_MODE_STD && frames > `CTPG_FRAMES_MAX
                        && state == ST_RD);
         if (take && busy)
            pend <= 1'b1;
         dly_sub <= (state != ST_DLY || dly_sub == `CTPG_US_LAST) ? 8'h00 :
                    dly_sub + 8'h01;
         case (state)
            ST_IDLE:
            begin
               if (take || pend)
               begin
                  pend    <= 1'b0;
                  state   <= ST_DLY;
                  dly_cnt <= delay_us;
                  if (mode == `CTPG_MODE_ASYN)
                     timing_reset_o <= 1'b1;
               end
            end
            ST_DLY:
            begin
               if (dly_cnt == 24'h0)
               begin
                  trig_delayed_o <= 1'b1;
                  expose_o <= 1'b1;
                  cyc_cnt  <= EXP_CYC;
                  state    <= ST_EXP;
               end
               else if (dly_sub == `CTPG_US_LAST)
                  dly_cnt <= dly_cnt - 24'h1;
            end
            ST_EXP:
            begin
               if (cyc_cnt <= 32'h1)
               begin
                  expose_o <= 1'b0;
                  if (mode == `CTPG_MODE_ACC)
                  begin
                     transfer_o <= 1'b1;
                     if (acc_cnt + 16'h1 >= pulses)
                     begin
                        acc_cnt   <= 16'h0;
                        readout_o <= 1'b1;
                        frm_cnt   <= 17'h1;
                        state     <= ST_RD;
                     end
                     else
                     begin
                        acc_cnt <= acc_cnt + 16'h1;
                        state   <= ST_IDLE;
                     end
                  end
                  else
                  begin
                     readout_o <= 1'b1;
                     frm_cnt   <= (mode == `CTPG_MODE_FAST ||
                                   mode == `CTPG_MODE_ASYN) ? 17'h1 : nfr;
                     state     <= ST_RD;
                  end
               end
               else
                  cyc_cnt <= cyc_cnt - 32'h1;
            end
            ST_RD:
            begin
               if (mode == `CTPG_MODE_FAST && (take || pend))
               begin
                  pend    <= 1'b0;
                  dly_cnt <= delay_us;
                  state   <= ST_DLY;
               end
               else if (frame_done_i)
               begin
                  if (mode == `CTPG_MODE_STD && frames > `CTPG_FRAMES_MAX)
                     frm_cnt <= 17'h1;
                  else if (frm_cnt <= 17'h1)
                  begin
                     readout_o <= 1'b0;
                     state     <= ST_IDLE;
                  end
                  else
                     frm_cnt <= frm_cnt - 17'h1;
               end
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // Pulse generator
   reg [31:0] pg_tick_cnt;
   reg [9:0]  pg_sub;
   reg [16:0] pg_sent;
   wire       pg_tick = us_tick && (pg_sub == gran_mul(pg_gran) - 10'd1);
   always @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         pg_run <= 1'b0; pg_sub <= 10'h0; pg_tick_cnt <= 32'h0;
         pg_sent <= 17'h0; pulse_gen_o <= 1'b0;
      end
      else if (pg_toggle)
      begin
         pg_run <= ~pg_run;
         pg_sub <= 10'h0; pg_tick_cnt <= 32'h0; pg_sent <= 17'h0;
         pulse_gen_o <= !pg_run && (pg_width != 32'h0);
      end
      else if (pg_run)
      begin
         if (us_tick)
            pg_sub <= pg_tick ? 10'h0 : pg_sub + 10'h1;
         if (pg_tick)
         begin
            if (pg_tick_cnt + 32'h1 >= pg_period)
            begin
               pg_tick_cnt <= 32'h0;
               if (pg_fixed && pg_sent + 17'h1 >= pg_count)
               begin
                  pg_run      <= 1'b0;
                  pulse_gen_o <= 1'b0;
               end
               else
               begin
                  pg_sent     <= pg_sent + 17'h1;
                  pulse_gen_o <= (pg_width != 32'h0);
               end
            end
            else
            begin
               pg_tick_cnt <= pg_tick_cnt + 32'h1;
               pulse_gen_o <= (pg_tick_cnt + 32'h1 < pg_width);
            end
         end
      end
   end

   // AXI4-Lite write path
   reg        aw_hold;
   reg        w_hold;
   reg [7:0]  aw_addr;
   reg [31:0] w_data;
   assign s_axi_awready = !aw_hold && !s_axi_bvalid;
   assign s_axi_wready  = !w_hold && !s_axi_bvalid;
   wire aw_now = aw_hold || s_axi_awvalid;
   wire w_now  = w_hold || s_axi_wvalid;
   wire [7:0]  wa = aw_hold ? aw_addr : s_axi_awaddr;
   wire [31:0] wd = w_hold ? w_data : s_axi_wdata;
   wire do_wr = aw_now && w_now && !s_axi_bvalid;
   always @(posedge clk_i)
   begin
      soft_trig <= 1'b0;
      pg_toggle <= 1'b0;
      if (sys_rst_i)
      begin
         aw_hold <= 1'b0; w_hold <= 1'b0; aw_addr <= 8'h0; w_data <= 32'h0;
         s_axi_bvalid <= 1'b0; s_axi_bresp <= 2'b00;
         ctrl <= `CTPG_CTRL_RST;
         frames <= 17'h1; pulses <= 16'h1; delay_us <= 24'h0;
         pg_gran <= 2'h0; pg_fixed <= 1'b0; pg_period <= 32'h2;
         pg_width <= 32'h1; pg_count <= 17'h1;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready && !do_wr)
         begin
            aw_hold <= 1'b1; aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready && !do_wr)
         begin
            w_hold <= 1'b1; w_data <= s_axi_wdata;
         end
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (do_wr)
         begin
            aw_hold <= 1'b0; w_hold <= 1'b0;
            s_axi_bvalid <= 1'b1; s_axi_bresp <= 2'b00;
            case (wa)
               `CTPG_REG_CTRL:      ctrl <= wd;
               `CTPG_REG_FRAMES:    frames <= (wd[16:0] == 17'h0) ? 17'h1 : wd[16:0];
               `CTPG_REG_PULSES:    pulses <= (wd[15:0] == 16'h0) ? 16'h1 : wd[15:0];
               `CTPG_REG_DELAY:     delay_us <= wd[23:0];
               `CTPG_REG_PG_CFG:
               begin
                  pg_gran <= wd[1:0]; pg_fixed <= wd[4];
               end
               `CTPG_REG_PG_PERIOD: pg_period <= wd;
               `CTPG_REG_PG_WIDTH:  pg_width <= wd;
               `CTPG_REG_PG_COUNT:  pg_count <= wd[16:0];
               `CTPG_REG_PG_CMD:    pg_toggle <= wd[0];
               `CTPG_REG_SW_TRIG:   soft_trig <= wd[0];
               default:             s_axi_bresp <= 2'b10;
            endcase
         end
      end
   end

   // AXI4-Lite read path
   assign s_axi_arready = !s_axi_rvalid;
   always @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         s_axi_rvalid <= 1'b0; s_axi_rdata <= 32'h0; s_axi_rresp <= 2'b00;
      end
      else if (s_axi_rvalid)
      begin
         if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
      else if (s_axi_arvalid)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= 2'b00;
         case (s_axi_araddr)
            `CTPG_REG_CTRL:      s_axi_rdata <= ctrl;
            `CTPG_REG_FRAMES:    s_axi_rdata <= {15'h0, frames};
            `CTPG_REG_PULSES:    s_axi_rdata <= {16'h0, pulses};
            `CTPG_REG_DELAY:     s_axi_rdata <= {8'h0, delay_us};
            `CTPG_REG_PG_CFG:    s_axi_rdata <= {27'h0, pg_fixed, 2'h0, pg_gran};
            `CTPG_REG_PG_PERIOD: s_axi_rdata <= pg_period;
            `CTPG_REG_PG_WIDTH:  s_axi_rdata <= pg_width;
            `CTPG_REG_PG_COUNT:  s_axi_rdata <= {15'h0, pg_count};
            `CTPG_REG_PG_CMD,
            `CTPG_REG_SW_TRIG:   s_axi_rdata <= 32'h0;
            `CTPG_REG_STATUS:    s_axi_rdata <= {26'h0, pend, pg_run, state};
            default:
            begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= 2'b10;
            end
         endcase
      end
   end

endmodule // ctpg_top

// ---- tb/ctpg_props.sv ----
`timescale 1ns/100ps
module ctpg_props
#(
   parameter EXP_CYC = 250
)
(
   // Clock and reset
   input wire        clk_i,
   input wire        sys_rst_i,
   // Register bus
   input wire [7:0]  s_axi_awaddr,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0]  s_axi_wstrb,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [7:0]  s_axi_araddr,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   // Trigger pins
   input wire        ext_trig_input_a_i,
   input wire        ext_trig_input_b_i,
   input wire        grabber_ctrl_input_a_i,
   input wire        grabber_ctrl_input_b_i,
   // Sensor timing core
   input wire        frame_done_i,
   input wire        expose_o,
   input wire        transfer_o,
   input wire        readout_o,
   input wire        timing_reset_o,
   input wire        free_run_o,
   input wire        trig_delayed_o,
   input wire        pulse_gen_o
);
   reg [15:0] exp_cnt;

   // Cycles spent in the current exposure
   always @(posedge clk_i)
   begin
      if (sys_rst_i || !expose_o)
         exp_cnt <= 16'h0000;
      else
         exp_cnt <= exp_cnt + 16'h0001;
   end

   default clocking dc @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   a_reset_idle: assert property (disable iff (1'b0) sys_rst_i |=>
      free_run_o && !expose_o && !readout_o && !s_axi_bvalid && !s_axi_rvalid)
      else $error("outputs not idle after reset");
   a_exp_len: assert property ($fell(expose_o) |-> exp_cnt == EXP_CYC)
      else $error("exposure length wrong");
   a_xfer_pulse: assert property (transfer_o |=> !transfer_o)
      else $error("transfer longer than one cycle");
   a_treset_pulse: assert property (timing_reset_o |=> !timing_reset_o)
      else $error("timing reset longer than one cycle");
   a_dly_pulse: assert property (trig_delayed_o |=> !trig_delayed_o)
      else $error("delayed trigger longer than one cycle");
   a_wr_answer: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
      else $error("write response late");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_wr_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_rd_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while response pending");
endmodule // ctpg_props

bind ctpg_top ctpg_props #(.EXP_CYC(EXP_CYC)) u_ctpg_props (
   .clk_i(clk_i), .sys_rst_i(sys_rst_i),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
   .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .ext_trig_input_a_i(ext_trig_input_a_i),
   .ext_trig_input_b_i(ext_trig_input_b_i),
   .grabber_ctrl_input_a_i(grabber_ctrl_input_a_i),
   .grabber_ctrl_input_b_i(grabber_ctrl_input_b_i),
   .frame_done_i(frame_done_i), .expose_o(expose_o),
   .transfer_o(transfer_o), .readout_o(readout_o),
   .timing_reset_o(timing_reset_o), .free_run_o(free_run_o),
   .trig_delayed_o(trig_delayed_o), .pulse_gen_o(pulse_gen_o));

// ---- tb/ctpg_sensor.sv ----
`timescale 1ns/100ps
module ctpg_sensor
#(
   parameter [7:0] FRAME_CYC = 8'h14
)
(
   // Clock and reset
   input  wire clk_i,
   input  wire sys_rst_i,
   // Readout request and frame end
   input  wire readout_i,
   output reg  frame_done_o
);
   reg [7:0] cnt;

   // One frame end pulse per FRAME_CYC readout cycles
   always @(posedge clk_i)
   begin
      if (sys_rst_i || !readout_i)
      begin
         cnt          <= 8'h00;
         frame_done_o <= 1'b0;
      end
      else
      begin
         cnt          <= (cnt == FRAME_CYC - 8'h01) ? 8'h00 : cnt + 8'h01;
         frame_done_o <= (cnt == FRAME_CYC - 8'h01);
      end
   end
endmodule // ctpg_sensor

// ---- tb/ctpg_top_tb.sv ----
`timescale 1ns/100ps
`include "ctpg_map.vh"
module ctpg_top_tb;
   integer     seed = 54553, n_mismatch = 0, n_tests = 0, cyc = 0, i, dly;
   integer     n_exp, n_fd, n_xfer, n_trst, n_dly, n_pg, t0, t_exp;
   integer     pg_hi, pg_w, pg_p, pg_t;
   reg         ovl_seen;
   reg         clk_i = 1'b0;
   reg         sys_rst_i = 1'b1;
   reg  [7:0]  awaddr = 8'h00;
   reg  [7:0]  araddr = 8'h00;
   reg  [31:0] wdata = 32'h0000_0000;
   reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   reg         arvalid = 1'b0, rready = 1'b0;
   reg  [3:0]  pin = 4'h0;
   reg  [31:0] rd, r;
   reg  [1:0]  rsp;
   wire        awready, wready, bvalid, arready, rvalid, fd;
   wire [1:0]  bresp, rresp;
   wire [31:0] rdata;
   wire        expose, xfer, rdout, treset, frun, tdly, pgo;

   ctpg_top #(.EXP_CYC(40)) u_ctpg_top (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .ext_trig_input_a_i(pin[0]), .ext_trig_input_b_i(pin[1]),
      .grabber_ctrl_input_a_i(pin[2]), .grabber_ctrl_input_b_i(pin[3]),
      .frame_done_i(fd), .expose_o(expose), .transfer_o(xfer),
      .readout_o(rdout), .timing_reset_o(treset), .free_run_o(frun),
      .trig_delayed_o(tdly), .pulse_gen_o(pgo));

   ctpg_sensor u_ctpg_sensor (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .readout_i(rdout), .frame_done_o(fd));

   // Clock, 4 ns period
   initial
   begin
      forever #2 clk_i = ~clk_i;
   end

   // Event counters, pulse timing and hang limit
   always @(posedge clk_i)
   begin
      cyc = cyc + 1;
      if ($rose(expose) && t_exp < 0)
         t_exp = cyc;
      n_exp = n_exp + $rose(expose);
      n_fd = n_fd + fd;
      n_xfer = n_xfer + xfer;
      n_trst = n_trst + treset;
      n_dly = n_dly + tdly;
      ovl_seen = ovl_seen | (expose & rdout);
      pg_hi = pg_hi + pgo;
      if ($rose(pgo))
      begin
         n_pg = n_pg + 1;
         pg_p = cyc - pg_t;
         pg_t = cyc;
      end
      if ($fell(pgo))
      begin
         pg_w = pg_hi;
         pg_hi = 0;
      end
      if (cyc == 90000)
      begin
         n_mismatch = n_mismatch + 1;
         wrap_up;
      end
   end

   function [31:0] ctl(input [2:0] src, input [2:0] md, input [1:0] ov,
                       input eg, input [2:0] db, input [3:0] pl);
      ctl = {12'h000, pl, 1'b0, db, 1'b0, eg, ov, 1'b0, md, 1'b0, src};
   endfunction

   task wrap_up;
   begin
      if (n_mismatch == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   end
   endtask

   task chk(input [8*10:1] nm, input [31:0] e, input [31:0] g);
   begin
      n_tests = n_tests + 1;
      if (g !== e)
      begin
         n_mismatch = n_mismatch + 1;
         $display("ERROR %0s expected %0h seen %0h", nm, e, g);
      end
   end
   endtask

   task wr(input [7:0] a, input [31:0] d);
   begin
      @(posedge clk_i);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge clk_i);
         if (awready === 1'b1)
            awvalid <= 1'b0;
         if (wready === 1'b1)
            wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1);
      rsp = bresp;
      bready <= 1'b0;
   end
   endtask

   task rd_reg(input [7:0] a);
   begin
      @(posedge clk_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge clk_i);
         if (arready === 1'b1)
            arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1);
      rd = rdata;
      rsp = rresp;
      rready <= 1'b0;
   end
   endtask

   task clr;
   begin
      {n_exp, n_fd, n_xfer, n_trst, n_dly, n_pg, pg_hi} = 0;
      t_exp = -1;
      ovl_seen = 1'b0;
   end
   endtask

   // Program control, let earlier activity settle, clear counts
   task setup(input [31:0] c);
   begin
      wr(`CTPG_REG_CTRL, c);
      repeat (200) @(posedge clk_i);
      clr;
   end
   endtask

   // Toggle a pin, hold, toggle back, then wait
   task trig(input [1:0] idx, input integer hold, input integer w);
   begin
      @(posedge clk_i);
      pin[idx] <= ~pin[idx];
      t0 = cyc;
      repeat (hold) @(posedge clk_i);
      pin[idx] <= ~pin[idx];
      repeat (w) @(posedge clk_i);
   end
   endtask

   // Main sequence
   initial
   begin
      clr;
      repeat (12) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      rd_reg(`CTPG_REG_CTRL);
      chk("ctrl_rst", ctl(0, 0, 0, 0, 3, 0), rd);
      rd_reg(`CTPG_REG_FRAMES);
      chk("frame_rst", 1, rd);
      rd_reg(`CTPG_REG_PULSES);
      chk("pulse_rst", 1, rd);
      rd_reg(8'h3C);
      chk("unmap_rsp", 2, rsp);
      chk("unmap_dat", 0, rd);
      wr(8'h3C, 0);
      chk("unmap_wr", 2, rsp);
      setup(ctl(`CTPG_SRC_OFF, 0, 0, 0, 0, 0));
      trig(0, 10, 1000);
      chk("off_exp", 0, n_exp);
      chk("off_free", 1, frun);
      for (i = 0; i < 5; i = i + 1)
      begin
         r = $random(seed);
         dly = r[3:2] % 3;
         wr(`CTPG_REG_DELAY, dly);
         wr(`CTPG_REG_FRAMES, 1 + r[5:4] % 3);
         setup(ctl(i == 4 ? `CTPG_SRC_SOFT : r[1] ? `CTPG_SRC_GRAB :
                   `CTPG_SRC_EXT, `CTPG_MODE_STD, 0, 0, 0, 0));
         if (i == 4)
            wr(`CTPG_REG_SW_TRIG, 1);
         if (i == 4)
            t0 = cyc;
         else
            trig(r[1:0], 10, 0);
         repeat (1200) @(posedge clk_i);
         chk("std_exp", 1, n_exp);
         chk("std_frm", 1 + r[5:4] % 3, n_fd);
         chk("delay", 1, t_exp - t0 >= dly * `CTPG_US_CYC - 2 &&
             t_exp - t0 <= dly * `CTPG_US_CYC + 16);
         chk("trig_dly", 1, n_dly);
      end
      wr(`CTPG_REG_DELAY, 0);
      wr(`CTPG_REG_FRAMES, 65501);
      setup(ctl(`CTPG_SRC_EXT, `CTPG_MODE_STD, 0, 0, 0, 0));
      trig(0, 10, 600);
      chk("frm_free", 1, frun);
      wr(`CTPG_REG_FRAMES, 5);
      setup(ctl(`CTPG_SRC_EXT, `CTPG_MODE_DBL, 0, 0, 0, 0));
      trig(0, 10, 1200);
      chk("dbl_frm", 2, n_fd);
      wr(`CTPG_REG_PULSES, 3);
      setup(ctl(`CTPG_SRC_EXT, `CTPG_MODE_ACC, 0, 0, 0, 0));
      trig(0, 10, 300);
      trig(0, 10, 300);
      chk("acc_xfer", 2, n_xfer);
      chk("acc_wait", 0, n_fd);
      trig(0, 10, 1200);
      chk("acc_xfer", 3, n_xfer);
      chk("acc_read", 1, n_fd > 0);
      setup(ctl(`CTPG_SRC_EXT, `CTPG_MODE_ASYN, 0, 0, 0, 0));
      trig(0, 10, 1200);
      chk("async", 1, n_trst);
      wr(`CTPG_REG_FRAMES, 3);
      for (i = 0; i < 4; i = i + 1)
      begin
         setup(ctl(`CTPG_SRC_EXT, `CTPG_MODE_STD, i == 3 ? 2 : i, 0, 0, 0));
         trig(0, 10, i == 3 ? 60 : 10);
         trig(0, 10, 1200);
         chk("overlap", i == 0 || i == 2 ? 1 : 2, n_exp);
      end
      setup(ctl(`CTPG_SRC_EXT, `CTPG_MODE_FAST, 1, 0, 0, 0));
      trig(0, 10, 40);
      trig(0, 10, 1200);
      chk("fast", 1, ovl_seen);
      for (i = 0; i < 2; i = i + 1)
      begin
         setup(ctl(i ? `CTPG_SRC_GRAB : `CTPG_SRC_EXT, 0, 0, !i, 0, i * 4));
         trig(i * 2, 300, 1200);
         chk("edge_pol", 1, n_exp == 1 && t_exp - t0 > 300);
      end
      setup(ctl(`CTPG_SRC_EXT, `CTPG_MODE_STD, 0, 0, 1, 0));
      trig(0, 1000, 3000);
      chk("deb_glitch", 0, n_exp);
      trig(0, 3000, 3500);
      chk("deb_pass", 1, n_exp == 1 && t_exp - t0 >= 2500 &&
          t_exp - t0 < 2600);
      wr(`CTPG_REG_PG_CFG, 32'h0000_0010);
      wr(`CTPG_REG_PG_PERIOD, 2);
      wr(`CTPG_REG_PG_WIDTH, 1);
      wr(`CTPG_REG_PG_COUNT, 3);
      clr;
      wr(`CTPG_REG_PG_CMD, 1);
      rd_reg(`CTPG_REG_STATUS);
      chk("pg_run", 1, rd[4]);
      repeat (2000) @(posedge clk_i);
      chk("pg_count", 3, n_pg);
      chk("pg_width", 250, pg_w);
      chk("pg_period", 500, pg_p);
      rd_reg(`CTPG_REG_STATUS);
      chk("pg_halt", 0, rd[4]);
      wr(`CTPG_REG_PG_CFG, 32'h0000_0001);
      clr;
      wr(`CTPG_REG_PG_CMD, 1);
      repeat (12000) @(posedge clk_i);
      chk("pg_cont", 1, n_pg >= 2 && pg_w == 2500);
      wr(`CTPG_REG_PG_CMD, 1);
      rd_reg(`CTPG_REG_STATUS);
      chk("pg_stop", 0, rd[4]);
      wrap_up;
   end
endmodule // ctpg_top_tb
